// ### core/wcu_regs.svh
`ifndef WCU_REGS_SVH
`define WCU_REGS_SVH
// ==========================================================
// clock and timing
`define WCU_CLK_MHZ 200
`define WCU_ERASE_ALL_MS 8000
`define WCU_PULSE_MS 100
// ==========================================================
// register byte offsets
`define WCU_CTRL_OFS 8'h00
`define WCU_SETUP_OFS 8'h04
`define WCU_CMD_OFS 8'h08
`define WCU_COPY_OFS 8'h0c
`define WCU_DIGIT_OFS 8'h10
`define WCU_COUNT_OFS 8'h14
`define WCU_STAT_OFS 8'h18
`define WCU_IRQ_STAT_OFS 8'h1c
`define WCU_IRQ_MASK_OFS 8'h20
`define WCU_DATA_OFS 8'h24
// ==========================================================
// control register fields
`define WCU_CTRL_REMOTE 0
`define WCU_CTRL_COUNT_ALL 1
`define WCU_CTRL_PULSED 2
`define WCU_CTRL_PRESS_OFF 3
`define WCU_CTRL_ONLINE 4
`define WCU_CTRL_W 5
`define WCU_CTRL_RESET 5'h02
// command register fields
`define WCU_CMD_INC 0
`define WCU_CMD_DEC 1
`define WCU_CMD_COPY 2
`define WCU_CMD_ERASE_CUR 3
`define WCU_CMD_ERASE_ALL 4
`define WCU_CMD_RESET_CNT 5
`define WCU_CMD_PRESET 6
`define WCU_CMD_YES 8
// interrupt status bits
`define WCU_IRQ_DONE 0
`define WCU_IRQ_BAD 1
`define WCU_IRQ_ERASED 2
`define WCU_IRQ_REFUSED 3
`define WCU_IRQ_W 4
// ==========================================================
// limits
`define WCU_PRESET_MAX 16'hea60
`define WCU_DIGITS 5
`endif

// ### core/wcu_pkg.sv
package wcu_pkg;
   // ==========================================================
   // weld cycle sequencer
   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_WELD,
      CYC_PRESS_ONLY,
      CYC_HOLD
   } wcu_cyc_type;

   // the four isolated status outputs
   typedef struct packed {
      logic dwell;
      logic ready;
      logic good;
      logic bad;
   } wcu_iso_type;

   // weld side inputs
   typedef struct packed {
      logic trigger;
      logic automation;
      logic palm_left;
      logic palm_right;
      logic weld_done;
      logic bad_limit;
      logic suspect_limit;
      logic dwell;
   } wcu_weld_in_type;
endpackage : wcu_pkg

// ### core/wcu_top.sv
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wcu_regs.svh"

// Overview of operation
// - eight setups, inc/dec selects active one
// - mode flag picks local or remote selection
// - remote: active setup follows selection bits
// - copy source to destination only when confirmed
// - erase current or all, only if confirmed
// - erase-all busy about eight seconds
// - confirmed reset clears part counter
// - count mode: all parts or good only
// - digit preset, refuse values above 60000
// - one mode bit, maintained by default
// - pulsed mode gives 100 ms pulse
// - outputs: bad, good, ready, in-dwell
// - offline ignores trigger, option set or not
// - offline option: both palms, no ultrasonics
// - offline: automation input never starts cycle
// - bad limit ends cycle; suspect flags only
module wcu_top #(
   parameter int unsigned ERASE_CYCLES = `WCU_ERASE_ALL_MS * 1000 * `WCU_CLK_MHZ,
   parameter int unsigned PULSE_CYCLES = `WCU_PULSE_MS * 1000 * `WCU_CLK_MHZ
) (
   input wire logic pclk, // bus and core clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic [2:0] remote_sel, // plc setup selection bits
   input wire wcu_pkg::wcu_weld_in_type weld_in, // trigger, palms, limits
   output logic press_cycle, // drive press down
   output logic us_enable, // ultrasonic output enable
   output wcu_pkg::wcu_iso_type iso_out, // isolated status outputs
   output logic erase_busy, // erase of all setups running
   output logic [2:0] active_setup, // active setup, 0 means setup 1
   output logic irq // level interrupt
);
   // ==========================================================
   // bus phase decode
   logic setup_ph;
   logic access_ph;
   logic wr_en;
   logic rd_en;
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & pready;
   assign wr_en = access_ph & pwrite;
   assign rd_en = access_ph & ~pwrite;

   logic [`WCU_CTRL_W-1:0] ctrl;
   logic [`WCU_IRQ_W-1:0] irq_stat;
   logic [`WCU_IRQ_W-1:0] irq_mask;
   logic [`WCU_IRQ_W-1:0] irq_set;
   logic [`WCU_IRQ_W-1:0] rd_clr;
   logic [2:0] copy_src;
   logic [2:0] copy_dst;
   logic [3:0] digit [`WCU_DIGITS];
   logic [15:0] part_count;
   logic [15:0] setup_data [8];
   logic [7:0] setup_valid;
   logic [31:0] erase_cnt;
   logic preset_err;
   wcu_pkg::wcu_cyc_type cyc_state;
   logic cyc_start;
   logic cyc_end;
   logic cyc_bad;
   logic cyc_suspect;
   logic done_bad;

   // ==========================================================
   // command decode, taken only at the write access edge
   logic cmd_wr;
   logic yes;
   logic idle_ok;
   assign cmd_wr = wr_en & (paddr == `WCU_CMD_OFS);
   assign yes = pwdata[`WCU_CMD_YES];
   assign idle_ok = cmd_wr & ~erase_busy;

   logic do_copy;
   logic do_erase_cur;
   logic do_erase_all;
   logic do_reset_cnt;
   logic do_preset;
   // copy, erase and count reset need the yes bit, preset does not; a no answer changes nothing
   assign do_copy = idle_ok & pwdata[`WCU_CMD_COPY] & yes;
   assign do_erase_cur = idle_ok & pwdata[`WCU_CMD_ERASE_CUR] & yes;
   assign do_erase_all = idle_ok & pwdata[`WCU_CMD_ERASE_ALL] & yes;
   assign do_reset_cnt = idle_ok & pwdata[`WCU_CMD_RESET_CNT] & yes;
   assign do_preset = idle_ok & pwdata[`WCU_CMD_PRESET];

   // ==========================================================
   // preset value built from decimal digits, digit 0 least significant
   logic [16:0] preset_val;
   assign preset_val = 17'(digit[0]) + 17'(digit[1]) * 17'd10 + 17'(digit[2]) * 17'd100
      + 17'(digit[3]) * 17'd1000 + 17'(digit[4]) * 17'd10000;
   logic preset_ok;
   assign preset_ok = preset_val <= 17'(`WCU_PRESET_MAX);

   // ==========================================================
   // control register; maintained outputs after reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= `WCU_CTRL_RESET;
      else if (wr_en && paddr == `WCU_CTRL_OFS)
         ctrl <= pwdata[`WCU_CTRL_W-1:0];
   end

   // copy operands and preset digits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         copy_src <= 3'h0;
         copy_dst <= 3'h0;
         for (int i = 0; i < `WCU_DIGITS; i++)
            digit[i] <= 4'h0;
      end
      else if (wr_en && paddr == `WCU_COPY_OFS)
      begin
         copy_src <= pwdata[2:0];
         copy_dst <= pwdata[6:4];
      end
      else if (wr_en && paddr == `WCU_DIGIT_OFS && pwdata[2:0] < 3'(`WCU_DIGITS)
               && pwdata[7:4] <= 4'h9)
         digit[pwdata[2:0]] <= pwdata[7:4];
   end

   // ==========================================================
   // active setup: local inc/dec saturating at 1 and 8, or remote bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         active_setup <= 3'h0;
      else if (ctrl[`WCU_CTRL_REMOTE])
         active_setup <= remote_sel;
      else if (idle_ok && pwdata[`WCU_CMD_INC] && active_setup != 3'h7)
         active_setup <= active_setup + 3'h1;
      else if (idle_ok && pwdata[`WCU_CMD_DEC] && active_setup != 3'h0)
         active_setup <= active_setup - 3'h1;
   end

   // ==========================================================
   // setup store: one data word and a configured bit per setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         setup_valid <= 8'h00;
         for (int i = 0; i < 8; i++)
            setup_data[i] <= 16'h0000;
      end
      else if (erase_busy && erase_cnt == 32'h1)
      begin
         // all setups wiped when the long erase ends
         setup_valid <= 8'h00;
         for (int i = 0; i < 8; i++)
            setup_data[i] <= 16'h0000;
      end
      else if (do_copy)
      begin
         setup_data[copy_dst] <= setup_data[copy_src];
         setup_valid[copy_dst] <= setup_valid[copy_src];
      end
      else if (do_erase_cur)
      begin
         setup_data[active_setup] <= 16'h0000;
         setup_valid[active_setup] <= 1'b0;
      end
      else if (wr_en && paddr == `WCU_DATA_OFS && !erase_busy)
      begin
         setup_data[active_setup] <= pwdata[15:0];
         setup_valid[active_setup] <= 1'b1;
      end
   end

   // ==========================================================
   // erase-all timer; busy stays up until the count runs out
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         erase_busy <= 1'b0;
         erase_cnt <= 32'h0;
      end
      else if (do_erase_all)
      begin
         erase_busy <= 1'b1;
         erase_cnt <= ERASE_CYCLES;
      end
      else if (erase_busy)
      begin
         erase_cnt <= erase_cnt - 32'h1;
         if (erase_cnt == 32'h1)
            erase_busy <= 1'b0;
      end
   end

   // ==========================================================
   // weld cycle sequencer
   logic online;
   logic palms;
   assign online = ctrl[`WCU_CTRL_ONLINE];
   assign palms = weld_in.palm_left & weld_in.palm_right;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cyc_state <= wcu_pkg::CYC_IDLE;
         press_cycle <= 1'b0;
         us_enable <= 1'b0;
         cyc_suspect <= 1'b0;
      end
      else
      begin
         case (cyc_state)
            wcu_pkg::CYC_IDLE:
            begin
               if (online && (weld_in.trigger || weld_in.automation || palms))
               begin
                  cyc_state <= wcu_pkg::CYC_WELD;
                  press_cycle <= 1'b1;
                  us_enable <= 1'b1;
                  cyc_suspect <= 1'b0;
               end
               // offline: trigger and automation ignored, palms only with option
               else if (!online && ctrl[`WCU_CTRL_PRESS_OFF] && palms)
               begin
                  cyc_state <= wcu_pkg::CYC_PRESS_ONLY;
                  press_cycle <= 1'b1;
                  us_enable <= 1'b0;
               end
            end
            wcu_pkg::CYC_WELD:
            begin
               if (weld_in.suspect_limit)
                  cyc_suspect <= 1'b1;
               // a bad limit cuts the weld short
               if (weld_in.bad_limit || weld_in.weld_done)
               begin
                  cyc_state <= wcu_pkg::CYC_HOLD;
                  press_cycle <= 1'b0;
                  us_enable <= 1'b0;
               end
            end
            wcu_pkg::CYC_PRESS_ONLY:
            begin
               // press follows the palms, no count and no ultrasonics
               if (!palms)
               begin
                  cyc_state <= wcu_pkg::CYC_HOLD;
                  press_cycle <= 1'b0;
               end
            end
            wcu_pkg::CYC_HOLD:
            begin
               // wait for every start request to drop before rearming
               if (!weld_in.trigger && !weld_in.automation && !palms)
                  cyc_state <= wcu_pkg::CYC_IDLE;
            end
            default:
            begin
               cyc_state <= wcu_pkg::CYC_IDLE;
               press_cycle <= 1'b0;
               us_enable <= 1'b0;
            end
         endcase
      end
   end

   assign cyc_start = (cyc_state == wcu_pkg::CYC_IDLE) & online
      & (weld_in.trigger | weld_in.automation | palms);
   assign cyc_end = (cyc_state == wcu_pkg::CYC_WELD) & (weld_in.bad_limit | weld_in.weld_done);
   assign cyc_bad = weld_in.bad_limit;
   assign done_bad = cyc_end & cyc_bad;

   // ==========================================================
   // part counter; reset wins over a count in the same cycle
   logic count_it;
   assign count_it = cyc_end & (ctrl[`WCU_CTRL_COUNT_ALL]
      | (~cyc_bad & ~cyc_suspect & ~weld_in.suspect_limit));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         part_count <= 16'h0000;
      else if (do_reset_cnt)
         part_count <= 16'h0000;
      else if (do_preset && preset_ok)
         part_count <= preset_val[15:0];
      else if (count_it)
         part_count <= part_count + 16'h1;
   end

   // refused preset flag, cleared by the next accepted preset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         preset_err <= 1'b0;
      else if (do_preset)
         preset_err <= ~preset_ok;
   end

   // ==========================================================
   // status conditions: bad and good held from cycle end to next start
   logic held_bad;
   logic held_good;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         held_bad <= 1'b0;
         held_good <= 1'b0;
      end
      else if (cyc_start)
      begin
         held_bad <= 1'b0;
         held_good <= 1'b0;
      end
      else if (cyc_end)
      begin
         held_bad <= cyc_bad;
         held_good <= ~cyc_bad & ~cyc_suspect & ~weld_in.suspect_limit;
      end
   end

   logic [3:0] cond;
   assign cond[0] = held_bad;
   assign cond[1] = held_good;
   assign cond[2] = online & (cyc_state == wcu_pkg::CYC_IDLE) & ~erase_busy;
   assign cond[3] = (cyc_state == wcu_pkg::CYC_WELD) & weld_in.dwell;

   // one shaper per output: level in maintained mode, timed pulse on a rise
   logic [3:0] cond_d;
   logic [3:0] iso_q;
   for (genvar g = 0; g < 4; g++)
   begin : g_iso
      logic [31:0] pcnt;
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            cond_d[g] <= 1'b0;
            pcnt <= 32'h0;
            iso_q[g] <= 1'b0;
         end
         else
         begin
            cond_d[g] <= cond[g];
            if (!ctrl[`WCU_CTRL_PULSED])
            begin
               pcnt <= 32'h0;
               iso_q[g] <= cond[g];
            end
            else if (cond[g] && !cond_d[g])
            begin
               pcnt <= PULSE_CYCLES - 32'h1;
               iso_q[g] <= 1'b1;
            end
            else if (pcnt != 32'h0)
               pcnt <= pcnt - 32'h1;
            else
               iso_q[g] <= 1'b0;
         end
      end
   end

   assign iso_out.bad = iso_q[0];
   assign iso_out.good = iso_q[1];
   assign iso_out.ready = iso_q[2];
   assign iso_out.dwell = iso_q[3];

   // ==========================================================
   // interrupts: sticky, cleared by reading; a new event wins
   assign irq_set[`WCU_IRQ_DONE] = cyc_end;
   assign irq_set[`WCU_IRQ_BAD] = done_bad;
   assign irq_set[`WCU_IRQ_ERASED] = erase_busy & (erase_cnt == 32'h1);
   assign irq_set[`WCU_IRQ_REFUSED] = do_preset & ~preset_ok;
   // only the bits returned to software are cleared, so none slip by
   assign rd_clr = (rd_en && paddr == `WCU_IRQ_STAT_OFS) ? prdata[`WCU_IRQ_W-1:0]
      : {`WCU_IRQ_W{1'b0}};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= {`WCU_IRQ_W{1'b0}};
      else
         irq_stat <= (irq_stat & ~rd_clr) | irq_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= {`WCU_IRQ_W{1'b0}};
      else if (wr_en && paddr == `WCU_IRQ_MASK_OFS)
         irq_mask <= pwdata[`WCU_IRQ_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat & irq_mask);
   end

   // ==========================================================
   // apb slave: read data captured in setup, one access cycle always
   logic [31:0] next_prdata;
   logic next_err;
   always_comb
   begin
      next_prdata = 32'h0;
      next_err = 1'b0;
      case (paddr)
         `WCU_CTRL_OFS: next_prdata = 32'(ctrl);
         `WCU_SETUP_OFS: next_prdata = 32'(active_setup);
         `WCU_CMD_OFS: next_prdata = 32'h0;
         `WCU_COPY_OFS: next_prdata = {25'h0, copy_dst, 1'b0, copy_src};
         `WCU_DIGIT_OFS: next_prdata = {12'h0, digit[4], digit[3], digit[2], digit[1], digit[0]};
         `WCU_COUNT_OFS: next_prdata = 32'(part_count);
         `WCU_STAT_OFS: next_prdata = {16'h0, setup_valid, 2'h0, 1'b0, preset_err,
            cyc_state == wcu_pkg::CYC_IDLE, press_cycle, us_enable, erase_busy};
         `WCU_IRQ_STAT_OFS: next_prdata = 32'(irq_stat);
         `WCU_IRQ_MASK_OFS: next_prdata = 32'(irq_mask);
         `WCU_DATA_OFS: next_prdata = 32'(setup_data[active_setup]);
         default: next_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph & next_err;
         if (setup_ph && !pwrite)
            prdata <= next_prdata;
      end
   end
endmodule : wcu_top

// ### dv/wcu_top_assertions.sv
`timescale 1ns/1ps
module wcu_top_assertions #(
   parameter int unsigned ERASE_CYCLES = 50
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [7:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic pslverr, // apb
   input wire logic [2:0] remote_sel, // plc bits
   input wire wcu_pkg::wcu_weld_in_type weld_in, // weld side
   input wire logic press_cycle, // press
   input wire logic us_enable, // ultrasonics
   input wire wcu_pkg::wcu_iso_type iso_out, // status outputs
   input wire logic erase_busy, // erase all
   input wire logic [2:0] active_setup, // setup
   input wire logic irq // interrupt
);
   int unsigned busy_n;
   logic palms;
   logic start_req;

   // ==========================================================
   // erase hold too long for a repetition
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         busy_n <= 0;
      else
         busy_n <= erase_busy ? busy_n + 1 : 0;

   // both palms and any start request
   assign palms = weld_in.palm_left && weld_in.palm_right;
   assign start_req = weld_in.trigger || weld_in.automation || palms;

   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_no_cause;
      !start_req ##1 $rose(press_cycle);
   endsequence
   sequence s_press_only;
      press_cycle && !us_enable;
   endsequence

   // ==========================================================
   // checks
   a_erase_len: assert property ($fell(erase_busy) |-> busy_n == ERASE_CYCLES)
      else $error("erase busy length wrong");
   a_no_us_alone: assert property (us_enable |-> press_cycle)
      else $error("ultrasonics without press");
   a_press_palms: assert property (s_press_only and !palms |=> !press_cycle)
      else $error("press kept after palm release");
   a_start_cause: assert property (not s_no_cause)
      else $error("press started without request");
   a_offline_start: assert property ($rose(press_cycle) && !us_enable |-> $past(palms))
      else $error("press only start without palms");
   a_bad_ends: assert property (us_enable && weld_in.bad_limit |=> !us_enable)
      else $error("bad limit did not end weld");
   a_done_ends: assert property (us_enable && weld_in.weld_done |=> !press_cycle)
      else $error("weld done did not end cycle");
   a_setup_cause: assert property ($changed(active_setup) |->
      $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2)
      || $past(remote_sel) != $past(remote_sel, 2))
      else $error("active setup changed alone");
endmodule : wcu_top_assertions

// ### dv/wcu_plc_model.sv
`timescale 1ns/1ps
module wcu_plc_model (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire wcu_pkg::wcu_weld_in_type want, // levels asked by bench
   input wire logic [2:0] want_sel, // setup asked by bench
   input wire logic us_enable, // ultrasonics running
   output wcu_pkg::wcu_weld_in_type weld_in, // to controller
   output logic [2:0] remote_sel // selection bits
);
   logic [3:0] run_n;

   // ==========================================================
   // weld ends after eight cycles of ultrasonics, like a timed weld
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         weld_in <= '0;
         remote_sel <= 3'h0;
         run_n <= 4'h0;
      end
      else
      begin
         weld_in <= {want[7:4], run_n == 4'h7, want[2:0]};
         remote_sel <= want_sel;
         run_n <= us_enable ? run_n + 4'h1 : 4'h0;
      end
endmodule : wcu_plc_model

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "wcu_regs.svh"
module testbench;
   localparam int unsigned EC = 50;
   localparam int unsigned PC = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] remote_sel;
   logic [2:0] want_sel = 3'h0;
   wcu_pkg::wcu_weld_in_type weld_in;
   wcu_pkg::wcu_weld_in_type want = '0;
   wcu_pkg::wcu_iso_type iso_out;
   logic press_cycle;
   logic us_enable;
   logic erase_busy;
   logic [2:0] active_setup;
   logic irq;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;

   // ==========================================================
   // clock, design and far side
   always #2.5 pclk = ~pclk;
   wcu_top #(.ERASE_CYCLES(EC), .PULSE_CYCLES(PC)) DUT (.*);
   wcu_plc_model plc (
      .pclk(pclk), .presetn(presetn), .want(want), .want_sel(want_sel),
      .us_enable(us_enable), .weld_in(weld_in), .remote_sel(remote_sel)
   );

   // hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         final_report();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic final_report();
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // request held until ready; one idle edge after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask : cycles

   task automatic wait_press(input logic lvl);
      repeat (200)
         if (press_cycle !== lvl)
            @(posedge pclk);
      chk(32'(press_cycle), 32'(lvl));
   endtask : wait_press

   // one triggered weld, limits once press moves
   task automatic weld(input logic b, input logic s);
      want.trigger <= 1'b1;
      wait_press(1'b1);
      want.bad_limit <= b;
      want.suspect_limit <= s;
      want.dwell <= 1'b1;
      if (!b)
      begin
         cycles(3);
         chk(32'(iso_out.dwell), 32'h1);
      end
      wait_press(1'b0);
      want <= '0;
      cycles(4);
   endtask : weld

   // ==========================================================
   // scenarios
   task automatic t_setup();
      rdc(`WCU_CTRL_OFS, 32'h2);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(err), 32'h1);
      wr(`WCU_CMD_OFS, 32'h2);
      chk(32'(active_setup), 32'h0);
      repeat (8) wr(`WCU_CMD_OFS, 32'h1);
      chk(32'(active_setup), 32'h7);
      want_sel <= 3'h2;
      wr(`WCU_CTRL_OFS, 32'h3);
      wr(`WCU_CMD_OFS, 32'h1);
      chk(32'(active_setup), 32'h2);
      want_sel <= 3'h5;
      cycles(4);
      chk(32'(active_setup), 32'h5);
      wr(`WCU_CTRL_OFS, 32'h2);
      wr(`WCU_CMD_OFS, 32'h2);
      chk(32'(active_setup), 32'h4);
      $display("setup select done");
   endtask : t_setup

   task automatic t_copy();
      wr(`WCU_DATA_OFS, 32'h5a);
      wr(`WCU_COPY_OFS, 32'h14);
      wr(`WCU_CMD_OFS, 32'h4);
      repeat (3) wr(`WCU_CMD_OFS, 32'h2);
      rdc(`WCU_DATA_OFS, 32'h0);
      wr(`WCU_CMD_OFS, 32'h104);
      rdc(`WCU_DATA_OFS, 32'h5a);
      wr(`WCU_CMD_OFS, 32'h8);
      rdc(`WCU_DATA_OFS, 32'h5a);
      wr(`WCU_CMD_OFS, 32'h108);
      rdc(`WCU_DATA_OFS, 32'h0);
      $display("copy and erase done");
   endtask : t_copy

   task automatic t_erase();
      int n = 0;
      wr(`WCU_DATA_OFS, 32'h77);
      wr(`WCU_IRQ_MASK_OFS, 32'h4);
      wr(`WCU_CMD_OFS, 32'h110);
      repeat (EC + 10)
      begin
         if (erase_busy === 1'b1)
            n++;
         @(posedge pclk);
      end
      chk(32'(n), 32'(EC));
      chk(32'(irq), 32'h1);
      rdc(`WCU_IRQ_STAT_OFS, 32'h4);
      cycles(1);
      chk(32'(irq), 32'h0);
      rdc(`WCU_DATA_OFS, 32'h0);
      $display("erase all done");
   endtask : t_erase

   task automatic t_count();
      wr(`WCU_CTRL_OFS, 32'h12);
      weld(1'b0, 1'b0);
      rdc(`WCU_COUNT_OFS, 32'h1);
      chk(32'(iso_out), 32'h6);
      weld(1'b0, 1'b1);
      rdc(`WCU_COUNT_OFS, 32'h2);
      wr(`WCU_CTRL_OFS, 32'h10);
      weld(1'b0, 1'b1);
      rdc(`WCU_COUNT_OFS, 32'h2);
      weld(1'b1, 1'b0);
      rdc(`WCU_COUNT_OFS, 32'h2);
      chk(32'(iso_out), 32'h5);
      weld(1'b0, 1'b0);
      rdc(`WCU_COUNT_OFS, 32'h3);
      wr(`WCU_CMD_OFS, 32'h20);
      rdc(`WCU_COUNT_OFS, 32'h3);
      wr(`WCU_CMD_OFS, 32'h120);
      rdc(`WCU_COUNT_OFS, 32'h0);
      $display("part count done");
   endtask : t_count

   task automatic t_preset();
      int i;
      wr(`WCU_IRQ_MASK_OFS, 32'h0);
      for (i = 0; i < 5; i++)
         wr(`WCU_DIGIT_OFS, (i == 4) ? 32'h64 : 32'(i));
      wr(`WCU_CMD_OFS, 32'h40);
      rdc(`WCU_COUNT_OFS, 32'hea60);
      wr(`WCU_DIGIT_OFS, 32'h10);
      wr(`WCU_CMD_OFS, 32'h40);
      rdc(`WCU_COUNT_OFS, 32'hea60);
      chk(32'(irq), 32'h0);
      wr(`WCU_IRQ_MASK_OFS, 32'h8);
      cycles(1);
      chk(32'(irq), 32'h1);
      rdc(`WCU_IRQ_STAT_OFS, 32'hb);
      cycles(1);
      chk(32'(irq), 32'h0);
      $display("preset done");
   endtask : t_preset

   task automatic t_pulse();
      int n = 0;
      wr(`WCU_CTRL_OFS, 32'h10);
      weld(1'b1, 1'b0);
      wr(`WCU_CTRL_OFS, 32'h16);
      fork
         weld(1'b0, 1'b0);
         repeat (200)
         begin
            if (iso_out.good === 1'b1)
               n++;
            @(posedge pclk);
         end
      join
      chk(32'(n), 32'(PC));
      $display("pulsed outputs done");
   endtask : t_pulse

   task automatic t_offline();
      wr(`WCU_CTRL_OFS, 32'h2);
      want.trigger <= 1'b1;
      cycles(20);
      chk(32'(press_cycle), 32'h0);
      want <= '0;
      wr(`WCU_CTRL_OFS, 32'ha);
      want.automation <= 1'b1;
      cycles(20);
      chk(32'(press_cycle), 32'h0);
      want.automation <= 1'b0;
      want.palm_left <= 1'b1;
      cycles(20);
      chk(32'(press_cycle), 32'h0);
      want.palm_right <= 1'b1;
      cycles(5);
      chk({30'h0, press_cycle, us_enable}, 32'h2);
      want <= '0;
      cycles(5);
      chk(32'(press_cycle), 32'h0);
      $display("offline press done");
   endtask : t_offline

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_setup();
      t_copy();
      t_erase();
      t_count();
      t_preset();
      t_pulse();
      t_offline();
      final_report();
   end
endmodule : testbench

bind wcu_top wcu_top_assertions #(.ERASE_CYCLES(ERASE_CYCLES)) chk_i (.*);
